// ===== param_cmd_pkg.sv
// shared constants and carriers for the parameter command handler
package param_cmd_pkg;
    localparam int FRAME_BYTES = 9;
    localparam logic [7:0] INSTR_SET_AXIS   = 8'h05;
    localparam logic [7:0] INSTR_GET_AXIS   = 8'h06;
    localparam logic [7:0] INSTR_SAVE_AXIS  = 8'h07;
    localparam logic [7:0] INSTR_REST_AXIS  = 8'h08;
    localparam logic [7:0] INSTR_SET_GLOBAL = 8'h09;
    localparam logic [7:0] INSTR_GET_GLOBAL = 8'h0A;
    localparam logic [7:0] INSTR_SAVE_GLOBAL = 8'h0B;
    localparam logic [7:0] BANK_MODULE = 8'h00;
    localparam logic [7:0] BANK_USER   = 8'h02;
    localparam logic [7:0] BANK_IRQ    = 8'h03;
    localparam logic [7:0] STATUS_OK        = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM   = 8'h01;
    localparam logic [7:0] STATUS_BAD_INSTR = 8'h02;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [3:0] RESET_COUNT = 4'h0;

    typedef struct packed {
        logic [7:0]  targetAddr;
        logic [7:0]  instr;
        logic [7:0]  paramType;
        logic [7:0]  motorBank;
        logic [31:0] value;
        logic [7:0]  checksum;
    } frame_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] value;
    } reply_t;
endpackage

// ===== parameter_command_handler.sv
// command interpreter for axis and global parameter access
`timescale 1ns/10ps
module parameter_command_handler #(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter int         NUM_PARAMS  = 256
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   rxValid,
    input  wire logic [7:0]             rxByte,
    input  wire logic                   standaloneMode,
    input  wire logic                   autoRestoreUser,
    output logic                        rxReady,
    output logic                        replyValid,
    output param_cmd_pkg::reply_t       reply,
    output logic [31:0]                 accumulator
);
    localparam int IW = $clog2(NUM_PARAMS);

    typedef enum logic [2:0] {
        ST_RESTORE = 3'b001,
        ST_COLLECT = 3'b010,
        ST_EXEC    = 3'b100
    } state_t;

    // working and non-volatile copies; bank 3 has no saved copy
    logic [31:0] axisWork [NUM_PARAMS];
    logic [31:0] axisNv   [NUM_PARAMS];
    logic [31:0] modWork  [NUM_PARAMS];
    logic [31:0] modNv    [NUM_PARAMS];
    logic [31:0] userWork [NUM_PARAMS];
    logic [31:0] userNv   [NUM_PARAMS];
    logic [31:0] irqWork  [NUM_PARAMS];

    state_t                state_ff, nxt_state;
    logic [71:0]           shift_ff, nxt_shift;
    logic [3:0]            byteCnt_ff, nxt_byteCnt;
    logic [7:0]            sum_ff, nxt_sum;
    logic [IW-1:0]         restIdx_ff, nxt_restIdx;
    logic                  rxReady_ff, nxt_rxReady;
    logic                  replyValid_ff, nxt_replyValid;
    param_cmd_pkg::reply_t reply_ff, nxt_reply;
    logic [31:0]           acc_ff, nxt_acc;

    param_cmd_pkg::frame_t frame;
    logic [IW-1:0]         memIdx;
    logic                  restoring;
    logic                  axisWrWork, axisWrNv, axisFromNv;
    logic                  modWr, modWrNv;
    logic                  userWr, userWrNv, userFromNv;
    logic                  irqWr;
    logic [31:0]           globRead;
    logic                  bankOk;

    assign frame     = param_cmd_pkg::frame_t'(shift_ff);
    assign restoring = (state_ff == ST_RESTORE);
    assign memIdx    = restoring ? restIdx_ff : frame.paramType[IW-1:0];

    always_comb begin
        unique case (frame.motorBank)
            param_cmd_pkg::BANK_MODULE: globRead = modWork[memIdx];
            param_cmd_pkg::BANK_USER:   globRead = userWork[memIdx];
            param_cmd_pkg::BANK_IRQ:    globRead = irqWork[memIdx];
            default:                    globRead = param_cmd_pkg::RESET_WORD;
        endcase
    end

    assign bankOk = (frame.motorBank == param_cmd_pkg::BANK_MODULE)
                 || (frame.motorBank == param_cmd_pkg::BANK_USER)
                 || (frame.motorBank == param_cmd_pkg::BANK_IRQ);

    always_comb begin
        nxt_state      = state_ff;
        nxt_shift      = shift_ff;
        nxt_byteCnt    = byteCnt_ff;
        nxt_sum        = sum_ff;
        nxt_restIdx    = restIdx_ff;
        nxt_rxReady    = rxReady_ff;
        nxt_replyValid = 1'b0;
        nxt_reply      = reply_ff;
        nxt_acc        = acc_ff;
        axisWrWork     = 1'b0;
        axisWrNv       = 1'b0;
        axisFromNv     = 1'b0;
        modWr          = 1'b0;
        modWrNv        = 1'b0;
        userWr         = 1'b0;
        userWrNv       = 1'b0;
        userFromNv     = 1'b0;
        irqWr          = 1'b0;
        unique case (state_ff)
            ST_RESTORE: begin
                // walk the whole table once; commands wait until done
                axisWrWork = 1'b1;
                axisFromNv = 1'b1;
                modWr      = 1'b1;
                userWr     = autoRestoreUser;
                userFromNv = 1'b1;
                nxt_restIdx = restIdx_ff + 1'b1;
                if (restIdx_ff == IW'(NUM_PARAMS - 1)) begin
                    nxt_state   = ST_COLLECT;
                    nxt_rxReady = 1'b1;
                end
            end
            ST_COLLECT: begin
                if (rxValid) begin
                    // value bytes arrive most significant first
                    nxt_shift   = {shift_ff[63:0], rxByte};
                    nxt_byteCnt = byteCnt_ff + 4'h1;
                    if (byteCnt_ff != 4'(param_cmd_pkg::FRAME_BYTES - 1)) begin
                        nxt_sum = sum_ff + rxByte;
                    end else begin
                        nxt_state   = ST_EXEC;
                        nxt_rxReady = 1'b0;
                    end
                end
            end
            ST_EXEC: begin
                nxt_state   = ST_COLLECT;
                nxt_rxReady = 1'b1;
                nxt_byteCnt = param_cmd_pkg::RESET_COUNT;
                nxt_sum     = param_cmd_pkg::RESET_BYTE;
                // frames for another address are dropped without reply
                nxt_replyValid = (frame.targetAddr == MODULE_ADDR);
                nxt_reply.status = param_cmd_pkg::STATUS_OK;
                nxt_reply.value  = param_cmd_pkg::RESET_WORD;
                if (frame.checksum != sum_ff) begin
                    nxt_reply.status = param_cmd_pkg::STATUS_BAD_SUM;
                end else if (nxt_replyValid) begin
                    unique case (frame.instr)
                        param_cmd_pkg::INSTR_SET_AXIS: begin
                            axisWrWork = 1'b1;
                        end
                        param_cmd_pkg::INSTR_GET_AXIS: begin
                            nxt_reply.value = axisWork[memIdx];
                            if (standaloneMode) begin
                                nxt_acc = axisWork[memIdx];
                            end
                        end
                        param_cmd_pkg::INSTR_SAVE_AXIS: begin
                            axisWrNv = 1'b1;
                        end
                        param_cmd_pkg::INSTR_REST_AXIS: begin
                            axisWrWork = 1'b1;
                            axisFromNv = 1'b1;
                        end
                        param_cmd_pkg::INSTR_SET_GLOBAL: begin
                            if (!bankOk) begin
                                nxt_reply.status = param_cmd_pkg::STATUS_BAD_VALUE;
                            end else begin
                                modWr = (frame.motorBank == param_cmd_pkg::BANK_MODULE);
                                modWrNv = modWr;
                                userWr = (frame.motorBank == param_cmd_pkg::BANK_USER);
                                irqWr = (frame.motorBank == param_cmd_pkg::BANK_IRQ);
                            end
                        end
                        param_cmd_pkg::INSTR_GET_GLOBAL: begin
                            if (!bankOk) begin
                                nxt_reply.status = param_cmd_pkg::STATUS_BAD_VALUE;
                            end else begin
                                nxt_reply.value = globRead;
                                nxt_acc = globRead;
                            end
                        end
                        param_cmd_pkg::INSTR_SAVE_GLOBAL: begin
                            // bank 3 has no saved copy, so it is refused
                            if (frame.motorBank == param_cmd_pkg::BANK_USER) begin
                                userWrNv = 1'b1;
                            end else if (frame.motorBank != param_cmd_pkg::BANK_MODULE) begin
                                nxt_reply.status = param_cmd_pkg::STATUS_BAD_VALUE;
                            end
                        end
                        default: begin
                            nxt_reply.status = param_cmd_pkg::STATUS_BAD_INSTR;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state = ST_RESTORE;
            end
        endcase
    end

    // memories carry no reset; the restore walk fills the axis and module working copies, and the user one when autoRestoreUser is set
    always_ff @(posedge clk) begin
        if (axisWrWork) begin
            axisWork[memIdx] <= axisFromNv ? axisNv[memIdx] : frame.value;
        end
        if (axisWrNv) begin
            axisNv[memIdx] <= axisWork[memIdx];
        end
        if (modWr) begin
            modWork[memIdx] <= restoring ? modNv[memIdx] : frame.value;
        end
        if (modWrNv) begin
            modNv[memIdx] <= frame.value;
        end
        if (userWr) begin
            userWork[memIdx] <= userFromNv ? userNv[memIdx] : frame.value;
        end
        if (userWrNv) begin
            userNv[memIdx] <= userWork[memIdx];
        end
        if (irqWr) begin
            irqWork[memIdx] <= frame.value;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff      <= ST_RESTORE;
            shift_ff      <= 72'h0;
            byteCnt_ff    <= param_cmd_pkg::RESET_COUNT;
            sum_ff        <= param_cmd_pkg::RESET_BYTE;
            restIdx_ff    <= '0;
            rxReady_ff    <= 1'b0;
            replyValid_ff <= 1'b0;
            reply_ff      <= '0;
            acc_ff        <= param_cmd_pkg::RESET_WORD;
        end else begin
            state_ff      <= nxt_state;
            shift_ff      <= nxt_shift;
            byteCnt_ff    <= nxt_byteCnt;
            sum_ff        <= nxt_sum;
            restIdx_ff    <= nxt_restIdx;
            rxReady_ff    <= nxt_rxReady;
            replyValid_ff <= nxt_replyValid;
            reply_ff      <= nxt_reply;
            acc_ff        <= nxt_acc;
        end
    end

    assign rxReady     = rxReady_ff;
    assign replyValid  = replyValid_ff;
    assign reply       = reply_ff;
    assign accumulator = acc_ff;
endmodule

// ===== param_cmd_checker.sv
// assertion checker for the parameter command handler
`timescale 1ns/10ps
module param_cmd_checker #(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter int         NUM_PARAMS  = 256
) (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic                  rxValid,
    input wire logic [7:0]            rxByte,
    input wire logic                  standaloneMode,
    input wire logic                  autoRestoreUser,
    input wire logic                  rxReady,
    input wire logic                  replyValid,
    input wire param_cmd_pkg::reply_t reply,
    input wire logic [31:0]           accumulator
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sum_ff, nxt_sum, instr_ff, nxt_instr, bank_ff, nxt_bank;
    logic       adrOk_ff, nxt_adrOk, take, frameEnd, good, bankOk;
    int         walk_ff, nxt_walk;
    assign take = rxValid && rxReady;
    assign frameEnd = take && cnt_ff == 4'h8;
    assign good = frameEnd && adrOk_ff && sum_ff == rxByte;
    assign bankOk = bank_ff inside {8'h00, 8'h02, 8'h03};
    always_comb begin
        {nxt_cnt, nxt_sum, nxt_instr} = {cnt_ff, sum_ff, instr_ff};
        {nxt_bank, nxt_adrOk} = {bank_ff, adrOk_ff};
        nxt_walk = (walk_ff < NUM_PARAMS) ? walk_ff + 1 : walk_ff;
        if (take) begin
            nxt_cnt = frameEnd ? 4'h0 : cnt_ff + 4'h1;
            nxt_sum = (cnt_ff == 4'h0) ? rxByte : sum_ff + rxByte;
            if (cnt_ff == 4'h0) nxt_adrOk = rxByte == MODULE_ADDR;
            if (cnt_ff == 4'h1) nxt_instr = rxByte;
            if (cnt_ff == 4'h3) nxt_bank = rxByte;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {cnt_ff, sum_ff, instr_ff, bank_ff, adrOk_ff} <= '0;
            walk_ff <= 0;
        end else begin
            {cnt_ff, sum_ff, instr_ff} <= {nxt_cnt, nxt_sum, nxt_instr};
            {bank_ff, adrOk_ff} <= {nxt_bank, nxt_adrOk};
            walk_ff <= nxt_walk;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // no byte is taken before the restore walk has finished
    AST_WALK_HOLD: assert property (rxReady |-> walk_ff == NUM_PARAMS)
        else $error("ready before restore walk ended");
    AST_WALK_END: assert property (walk_ff == NUM_PARAMS - 1 |-> ##1 rxReady)
        else $error("ready late after restore walk");
    AST_EXEC_GAP: assert property (frameEnd |=> !rxReady ##1 rxReady)
        else $error("exec gap wrong after ninth byte");
    AST_REPLY_CAUSE: assert property (replyValid |-> $past(frameEnd, 2))
        else $error("reply without frame end");
    AST_FOREIGN: assert property (frameEnd && !adrOk_ff |-> ##2 !replyValid)
        else $error("reply to foreign address");
    AST_BAD_SUM: assert property (frameEnd && adrOk_ff && sum_ff != rxByte
        |-> ##2 reply.status == param_cmd_pkg::STATUS_BAD_SUM)
        else $error("bad checksum not reported");
    AST_WRITE_OK: assert property (good && instr_ff inside {8'h05, 8'h07, 8'h08}
        |-> ##2 replyValid && reply.status == param_cmd_pkg::STATUS_OK)
        else $error("axis write status wrong");
    AST_GET_DIRECT: assert property (good && instr_ff == 8'h06 && !standaloneMode
        |-> ##2 accumulator == $past(accumulator, 2))
        else $error("direct read touched accumulator");
    AST_GET_PROG: assert property (good && instr_ff == 8'h06 && standaloneMode
        |-> ##2 accumulator == reply.value)
        else $error("program read did not load accumulator");
    AST_GLOBAL_OK: assert property (good && instr_ff inside {8'h09, 8'h0A} && bankOk
        |-> ##2 reply.status == param_cmd_pkg::STATUS_OK)
        else $error("global access status wrong");
    AST_GET_GLOBAL: assert property (good && instr_ff == 8'h0A && bankOk
        |-> ##2 accumulator == reply.value)
        else $error("global read did not load accumulator");
    AST_SAVE_USER: assert property (good && instr_ff == 8'h0B && bank_ff == 8'h02
        |-> ##2 reply.status == param_cmd_pkg::STATUS_OK)
        else $error("user store status wrong");
    cover property (good && instr_ff == 8'h06 && standaloneMode);
    cover property (frameEnd && !adrOk_ff);
    cover property (good && instr_ff == 8'h0B);
endmodule
bind parameter_command_handler param_cmd_checker #(.MODULE_ADDR(MODULE_ADDR),
    .NUM_PARAMS(NUM_PARAMS)) chk_u (.clk(clk), .reset_n(reset_n),
    .rxValid(rxValid), .rxByte(rxByte), .standaloneMode(standaloneMode),
    .autoRestoreUser(autoRestoreUser), .rxReady(rxReady),
    .replyValid(replyValid), .reply(reply), .accumulator(accumulator));

// ===== host_frame_model.sv
// host model that frames command bytes and hands them over
`timescale 1ns/10ps
module host_frame_model (
    input  wire logic       clk,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output int              hangs
);
    initial begin
        {rxValid, rxByte, hangs} = '0;
    end
    // bad adds one to the checksum so the frame must be refused
    task automatic send(input logic [7:0] adr, ins, typ, bnk,
                        input logic [31:0] v, input logic bad);
        logic [7:0] by [9];
        int w;
        by = '{adr, ins, typ, bnk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        by[8] = adr + ins + typ + bnk + v[31:24] + v[23:16] + v[15:8] + v[7:0]
            + {7'h00, bad};
        @(posedge clk);
        for (int k = 0; k < 9; k++) begin
            rxValid <= 1'b1;
            rxByte  <= by[k];
            w = 0;
            do begin @(posedge clk); w++; end while (!rxReady && w < 400);
            if (w >= 400) hangs++;
        end
        rxValid <= 1'b0;
        // idle line shows a changed value so stale data never looks valid
        rxByte  <= ~by[8];
    endtask
endmodule

// ===== parameter_command_handler_bench.sv
// self-checking bench for the parameter command handler
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module parameter_command_handler_bench;
    localparam int NP = 16;
    logic clk = 1'b0, reset_n = 1'b0, standaloneMode = 1'b0;
    logic autoRestoreUser = 1'b1, rxValid, rxReady, replyValid;
    logic [7:0] rxByte;
    logic [31:0] accumulator, acc0;
    param_cmd_pkg::reply_t reply;
    int n_fail = 0, total_checks = 0, hangs;
    always #10 clk = ~clk;
    parameter_command_handler #(.MODULE_ADDR(8'h01), .NUM_PARAMS(NP)) dut_u (
        .clk(clk), .reset_n(reset_n), .rxValid(rxValid), .rxByte(rxByte),
        .standaloneMode(standaloneMode), .autoRestoreUser(autoRestoreUser),
        .rxReady(rxReady), .replyValid(replyValid), .reply(reply),
        .accumulator(accumulator));
    host_frame_model host_u (.clk(clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxByte(rxByte), .hangs(hangs));
    task automatic end_sim;
        n_fail += hangs;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        int w;
        @(posedge clk) reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        w = 0;
        do begin @(posedge clk); w++; end while (!rxReady && w < 400);
        `CHK("ready delay", NP + 1, w)
    endtask
    // value compared only for reads, the other replies carry zero
    task automatic xfer(input logic [7:0] adr, ins, typ, bnk,
        input logic [31:0] v, input logic bad, input logic [7:0] st,
        input logic [31:0] rv);
        host_u.send(adr, ins, typ, bnk, v, bad);
        // reply is registered one edge after the ninth byte and lasts a cycle
        @(posedge clk);
        #1;
        if (adr != 8'h01) `CHK("no reply", 1'b0, replyValid)
        else begin
            `CHK("reply strobe", 1'b1, replyValid)
            `CHK("status", st, reply.status)
            if (st == 8'h64 && ins inside {8'h06, 8'h0A})
                `CHK("value", rv, reply.value)
        end
    endtask
    task automatic t_axis;
        acc0 = accumulator;
        xfer(8'h01, 8'h05, 8'h04, 8'h00, 32'h0000_03E8, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h06, 8'h04, 8'h00, 32'hFFFF_FFFF, 1'b0, 8'h64, 32'h3E8);
        `CHK("acc direct", acc0, accumulator)
        @(posedge clk) standaloneMode <= 1'b1;
        xfer(8'h01, 8'h06, 8'h04, 8'h00, 32'h0, 1'b0, 8'h64, 32'h3E8);
        `CHK("acc program", 32'h0000_03E8, accumulator)
        @(posedge clk) standaloneMode <= 1'b0;
        xfer(8'h01, 8'h07, 8'h04, 8'h00, 32'h1234_5678, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h05, 8'h04, 8'h00, 32'hABCD_0001, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h08, 8'h04, 8'h00, 32'h5555_AAAA, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h06, 8'h04, 8'h00, 32'h0, 1'b0, 8'h64, 32'h3E8);
        $display("test axis done");
    endtask
    task automatic t_global;
        logic [7:0] bk [3] = '{8'h00, 8'h02, 8'h03};
        for (int i = 0; i < 3; i++) begin
            xfer(8'h01, 8'h09, 8'h2A, bk[i], {24'h1, bk[i]}, 1'b0, 8'h64, 0);
            xfer(8'h01, 8'h0A, 8'h2A, bk[i], 0, 1'b0, 8'h64, {24'h1, bk[i]});
            `CHK("acc global", {24'h1, bk[i]}, accumulator)
        end
        xfer(8'h01, 8'h0B, 8'h2A, 8'h02, 0, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h0B, 8'h2A, 8'h00, 0, 1'b0, 8'h64, 0);
        xfer(8'h01, 8'h0B, 8'h2A, 8'h03, 0, 1'b0, 8'h04, 0);
        xfer(8'h01, 8'h09, 8'h2A, 8'h01, 0, 1'b0, 8'h04, 0);
        xfer(8'h01, 8'h09, 8'h2A, 8'h02, 32'hDEAD, 1'b0, 8'h64, 0);
        $display("test global done");
    endtask
    task automatic t_errors;
        xfer(8'h01, 8'h05, 8'h04, 8'h00, 32'h77, 1'b1, 8'h01, 0);
        xfer(8'h07, 8'h05, 8'h04, 8'h00, 32'h66, 1'b0, 8'h00, 0);
        xfer(8'h01, 8'h20, 8'h04, 8'h00, 32'h0, 1'b0, 8'h02, 0);
        xfer(8'h01, 8'h06, 8'h04, 8'h00, 32'h0, 1'b0, 8'h64, 32'h3E8);
        $display("test errors done");
    endtask
    task automatic t_restore;
        xfer(8'h01, 8'h05, 8'h04, 8'h00, 32'h0BAD_0BAD, 1'b0, 8'h64, 0);
        do_reset();
        xfer(8'h01, 8'h06, 8'h04, 8'h00, 32'h0, 1'b0, 8'h64, 32'h3E8);
        xfer(8'h01, 8'h0A, 8'h2A, 8'h00, 32'h0, 1'b0, 8'h64, 32'h100);
        xfer(8'h01, 8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h64, 32'h102);
        xfer(8'h01, 8'h09, 8'h2A, 8'h02, 32'hDEAD, 1'b0, 8'h64, 0);
        @(posedge clk) autoRestoreUser <= 1'b0;
        do_reset();
        xfer(8'h01, 8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0, 8'h64, 32'hDEAD);
        @(posedge clk) autoRestoreUser <= 1'b1;
        $display("test restore done");
    endtask
    initial begin
        do_reset();
        t_axis();
        t_global();
        t_errors();
        t_restore();
        end_sim();
    end
endmodule
